// file: common/stop_brake_pkg.sv
// constants, types and register map of the stop and brake select block
package stop_brake_pkg;

  // ----------------------------------------
  // clock and seconds tick
  // ----------------------------------------
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TICK_PERIOD_S   = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * TICK_PERIOD_S;

  // ----------------------------------------
  // bus and field widths
  // ----------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int COAST_W  = 14;
  localparam int DELAY_W  = 7;
  localparam int DUTY_W   = 7;
  localparam int POL_W    = 3;
  localparam int REGEN_W  = 2;
  localparam int RATING_W = 2;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_COAST  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REGEN  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DUTY   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_POL    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RATING = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // ----------------------------------------
  // coast delay setting codes
  // ----------------------------------------
  localparam logic [COAST_W-1:0] COAST_DECEL_A  = 14'h270F;
  localparam logic [COAST_W-1:0] COAST_DECEL_B  = 14'h22B8;
  localparam logic [COAST_W-1:0] COAST_DIR_MAX  = 14'h0064;
  localparam logic [COAST_W-1:0] COAST_EXT_BASE = 14'h03E8;
  localparam logic [COAST_W-1:0] COAST_EXT_MAX  = 14'h044C;
  localparam logic [COAST_W-1:0] COAST_RST      = COAST_DECEL_A;

  // ----------------------------------------
  // brake and polarity codes
  // ----------------------------------------
  localparam logic [REGEN_W-1:0]  REGEN_NONE  = 2'h0;
  localparam logic [REGEN_W-1:0]  REGEN_MAX   = 2'h2;
  localparam logic [REGEN_W-1:0]  REGEN_RST   = 2'h0;
  localparam logic [DUTY_W-1:0]   DUTY_MAX    = 7'h64;
  localparam logic [DUTY_W-1:0]   DUTY_RST    = 7'h00;
  localparam logic [DUTY_W-1:0]   DUTY_CLASS0 = 7'h00;
  localparam logic [DUTY_W-1:0]   DUTY_CLASS1 = 7'h03;
  localparam logic [DUTY_W-1:0]   DUTY_CLASS2 = 7'h02;
  localparam logic [RATING_W-1:0] RATING_MAX  = 2'h2;
  localparam logic [RATING_W-1:0] RATING_RST  = 2'h0;
  localparam logic [POL_W-1:0]    POL_MAX     = 3'h5;
  localparam logic [POL_W-1:0]    POL_RST     = 3'h0;
  localparam logic [POL_W-1:0]    POL_STOP_NC = 3'h2;
  localparam logic [POL_W-1:0]    POL_SPLIT   = 3'h4;

  // ----------------------------------------
  // status register layout
  // ----------------------------------------
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CNT_LSB   = 4;
  localparam int ST_RUN_BIT   = 12;
  localparam int ST_X10_BIT   = 13;
  localparam int ST_STOP_BIT  = 14;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_RUN        = 3'b001,
    ST_COAST_WAIT = 3'b011,
    ST_COASTING   = 3'b010,
    ST_DECEL      = 3'b101
  } stop_state_e;

  typedef struct packed {
    logic running;
    logic output_on;
    logic follow_cmd;
    logic decel_stop;
    logic zero_hold;
    logic from_start;
  } drive_s;

endpackage

// file: core/second_tick.sv
// divider that makes a one-cycle pulse once per second
`timescale 1ns/1ps
`default_nettype none
module second_tick #(
  parameter int unsigned CYCLES = 40_000_000
) (
  // clock and reset
  input  wire logic CLOCK,
  input  wire logic RST,
  // restart of the phase
  input  wire logic restart,
  // one-cycle tick
  output var  logic tick
);

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // count cycles, wrap and pulse at the end of each period
  always_ff @(posedge CLOCK) begin
    if (RST || restart) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: core/stop_brake_select.sv
// stop sequencing and brake configuration with an apb register file
//
// Functional notes
// - start removed with coasting selected: keep output for the delay, then shut off
// - setting 1000 to 1100 gives a delay of setting minus 1000 seconds
// - after the delay the motor is left to coast, no controlled deceleration
// - running status drops the moment the output is shut off
// - coasting ignored during position control, power-fail, panel or comm-error stop
// - during the coast delay the output keeps following the frequency command
// - restart while coasting resumes from the starting frequency
// - pre-excitation input gives zero-speed hold instead of coasting
// - regenerative select codes 0 none, 1 heavy resistor, 2 external unit
// - select 0 ignores duty setting and uses fixed duty by rating class
// - brake duty limit accepts 0 to 100 percent, resets to 0
// - run-enable input normally open for 0,2,4 and closed for 1,3,5
// - output-stop normally open 0,1, closed 2,3, split terminal/comm for 4,5; for 2,3 the code takes the terminal only and ignores comm
// - converter drives run-enable; its state shuts the output off
// - setting 9999 or 8888 decelerates to a stop when start is removed
// - setting 0 to 100 shuts off that many seconds after start removal
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module stop_brake_select
  import stop_brake_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = stop_brake_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                                CLOCK,
  input  wire logic                                RST,
  // apb slave
  input  wire logic                                PSEL,
  input  wire logic                                PENABLE,
  input  wire logic                                PWRITE,
  input  wire logic [stop_brake_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [stop_brake_pkg::DATA_W-1:0]   PWDATA,
  output var  logic [stop_brake_pkg::DATA_W-1:0]   PRDATA,
  output var  logic                                PREADY,
  output var  logic                                PSLVERR,
  // operator and motion inputs
  input  wire logic                                START_CMD,
  input  wire logic                                MOTOR_STOPPED,
  input  wire logic                                PREEXCITE,
  // stop functions that disable coasting
  input  wire logic                                POSITION_CTRL,
  input  wire logic                                POWER_FAIL_STOP,
  input  wire logic                                PANEL_STOP,
  input  wire logic                                COMM_ERROR_STOP,
  // contact inputs, raw level
  input  wire logic                                RUN_ENABLE_IN,
  input  wire logic                                OUTPUT_STOP_TERM,
  input  wire logic                                OUTPUT_STOP_COMM,
  // drive and brake outputs
  output var  stop_brake_pkg::drive_s              DRIVE,
  output var  logic [stop_brake_pkg::DUTY_W-1:0]   BRAKE_DUTY
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [COAST_W-1:0]  coast_delay_setting;
  logic [REGEN_W-1:0]  regen_function_select;
  logic [DUTY_W-1:0]   brake_duty_limit;
  logic [POL_W-1:0]    input_polarity_select;
  logic [RATING_W-1:0] rating_class;
  stop_state_e         state;
  stop_state_e         next_state;
  drive_s              next_drive;
  logic [DELAY_W-1:0]  sec_cnt;
  logic [DELAY_W-1:0]  delay_s;
  logic                coast_valid;
  logic                coast_inhibit;
  logic                x10_shut;
  logic                stop_shut;
  logic                interlock;
  logic                expired;
  logic                tick;
  logic                setup;
  logic                wr_en;
  logic                bad_addr;
  logic                bad_value;
  logic [DATA_W-1:0]   rd_mux;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

  // read mux and address decode
  always_comb begin
    rd_mux   = '0;
    bad_addr = 1'b0;
    case (PADDR)
      OFS_COAST:  rd_mux[COAST_W-1:0]  = coast_delay_setting;
      OFS_REGEN:  rd_mux[REGEN_W-1:0]  = regen_function_select;
      OFS_DUTY:   rd_mux[DUTY_W-1:0]   = brake_duty_limit;
      OFS_POL:    rd_mux[POL_W-1:0]    = input_polarity_select;
      OFS_RATING: rd_mux[RATING_W-1:0] = rating_class;
      OFS_STATUS: begin
        rd_mux[ST_STATE_LSB +: 3]     = state;
        rd_mux[ST_CNT_LSB +: DELAY_W] = sec_cnt;
        rd_mux[ST_RUN_BIT]            = DRIVE.running;
        rd_mux[ST_X10_BIT]            = x10_shut;
        rd_mux[ST_STOP_BIT]           = stop_shut;
      end
      default:    bad_addr = 1'b1;
    endcase
  end

  // out-of-range values are refused with an error, old value kept
  always_comb begin
    bad_value = 1'b0;
    case (PADDR)
      OFS_COAST: bad_value = (PWDATA > DATA_W'(COAST_DIR_MAX))
                          && !(PWDATA >= DATA_W'(COAST_EXT_BASE)
                               && PWDATA <= DATA_W'(COAST_EXT_MAX))
                          && PWDATA != DATA_W'(COAST_DECEL_A)
                          && PWDATA != DATA_W'(COAST_DECEL_B);
      OFS_REGEN:  bad_value = PWDATA > DATA_W'(REGEN_MAX);
      OFS_DUTY:   bad_value = PWDATA > DATA_W'(DUTY_MAX);
      OFS_POL:    bad_value = PWDATA > DATA_W'(POL_MAX);
      OFS_RATING: bad_value = PWDATA > DATA_W'(RATING_MAX);
      OFS_STATUS: bad_value = 1'b1;
      default:    bad_value = 1'b0;
    endcase
  end

  // answer in the first access cycle, data latched at setup
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && (bad_addr || (PWRITE && bad_value));
      PRDATA  <= (setup && !PWRITE) ? rd_mux : '0;
    end
  end

  // ----------------------------------------
  // setting registers
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      coast_delay_setting   <= COAST_RST;
      regen_function_select <= REGEN_RST;
      brake_duty_limit      <= DUTY_RST;
      input_polarity_select <= POL_RST;
      rating_class          <= RATING_RST;
    end else if (wr_en) begin
      case (PADDR)
        OFS_COAST:  coast_delay_setting   <= PWDATA[COAST_W-1:0];
        OFS_REGEN:  regen_function_select <= PWDATA[REGEN_W-1:0];
        OFS_DUTY:   brake_duty_limit      <= PWDATA[DUTY_W-1:0];
        OFS_POL:    input_polarity_select <= PWDATA[POL_W-1:0];
        OFS_RATING: rating_class          <= PWDATA[RATING_W-1:0];
        default:    ;
      endcase
    end
  end

  // ----------------------------------------
  // contact polarity and interlock
  // ----------------------------------------
  // odd settings take run-enable as normally closed
  assign x10_shut = input_polarity_select[0] ? !RUN_ENABLE_IN : RUN_ENABLE_IN;
  // output stop: open, closed on terminal with comm ignored, or closed on terminal and open on comm
  always_comb begin
    if (input_polarity_select >= POL_SPLIT) begin
      stop_shut = !OUTPUT_STOP_TERM || OUTPUT_STOP_COMM;
    end else if (input_polarity_select >= POL_STOP_NC) begin
      stop_shut = !OUTPUT_STOP_TERM;
    end else begin
      stop_shut = OUTPUT_STOP_TERM || OUTPUT_STOP_COMM;
    end
  end
  assign interlock = x10_shut || stop_shut;

  // ----------------------------------------
  // coast delay decode
  // ----------------------------------------
  always_comb begin
    coast_valid = 1'b1;
    delay_s     = '0;
    if (coast_delay_setting <= COAST_DIR_MAX) begin
      delay_s = coast_delay_setting[DELAY_W-1:0];
    end else if (coast_delay_setting >= COAST_EXT_BASE
                 && coast_delay_setting <= COAST_EXT_MAX) begin
      delay_s = DELAY_W'(coast_delay_setting - COAST_EXT_BASE);
    end else begin
      coast_valid = 1'b0;
    end
  end
  assign coast_inhibit = POSITION_CTRL || POWER_FAIL_STOP
                      || PANEL_STOP || COMM_ERROR_STOP;
  assign expired = sec_cnt >= delay_s;

  // ----------------------------------------
  // seconds timing
  // ----------------------------------------
  second_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .CLOCK   (CLOCK),
    .RST     (RST),
    .restart (state != ST_COAST_WAIT),
    .tick    (tick)
  );

  // seconds counter, held clear outside the delay
  always_ff @(posedge CLOCK) begin
    if (RST || START_CMD || state != ST_COAST_WAIT) begin
      sec_cnt <= '0;
    end else if (tick && !expired) begin
      sec_cnt <= sec_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // stop sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (START_CMD) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (!START_CMD) begin
          if (coast_valid && !coast_inhibit) begin
            next_state = ST_COAST_WAIT;
          end else begin
            next_state = ST_DECEL;
          end
        end
      end
      ST_COAST_WAIT: begin
        if (START_CMD) begin
          next_state = ST_RUN;
        end else if (expired) begin
          next_state = ST_COASTING;
        end
      end
      ST_COASTING: begin
        if (START_CMD) begin
          next_state = ST_RUN;
        end else if (MOTOR_STOPPED && !PREEXCITE) begin
          next_state = ST_IDLE;
        end
      end
      ST_DECEL: begin
        if (START_CMD) begin
          next_state = ST_RUN;
        end else if (MOTOR_STOPPED) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // drive outputs
  // ----------------------------------------
  always_comb begin
    next_drive            = '0;
    next_drive.follow_cmd = !interlock
                         && (state == ST_RUN || state == ST_COAST_WAIT);
    next_drive.decel_stop = !interlock && state == ST_DECEL;
    next_drive.zero_hold  = !interlock && state == ST_COASTING && PREEXCITE;
    next_drive.output_on  = next_drive.follow_cmd || next_drive.decel_stop
                         || next_drive.zero_hold;
    next_drive.running    = next_drive.follow_cmd || next_drive.decel_stop;
    next_drive.from_start = state == ST_COASTING && next_state == ST_RUN;
  end

  // registered drive word and brake duty
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DRIVE      <= '0;
      BRAKE_DUTY <= DUTY_CLASS0;
    end else begin
      DRIVE <= next_drive;
      if (regen_function_select == REGEN_NONE) begin
        case (rating_class)
          2'h1:    BRAKE_DUTY <= DUTY_CLASS1;
          2'h2:    BRAKE_DUTY <= DUTY_CLASS2;
          default: BRAKE_DUTY <= DUTY_CLASS0;
        endcase
      end else begin
        BRAKE_DUTY <= brake_duty_limit;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_wait_done;
    state == ST_COAST_WAIT && !START_CMD && expired;
  endsequence
  sequence s_coast_quiet;
    state == ST_COASTING && !PREEXCITE;
  endsequence

  chk_coast_expire: assert property (@(posedge CLOCK) disable iff (RST)
    s_wait_done |=> s_coast_quiet or (state == ST_COASTING))
    else $error("coast delay expired without output shutoff");
  chk_coast_free: assert property (@(posedge CLOCK) disable iff (RST)
    s_coast_quiet |=> !DRIVE.output_on && !DRIVE.decel_stop)
    else $error("output still driven while coasting");
  chk_running_drop: assert property (@(posedge CLOCK) disable iff (RST)
    state == ST_COASTING |=> !DRIVE.running && !DRIVE.follow_cmd)
    else $error("running shown with output shut off");
  chk_inhibit_decel: assert property (@(posedge CLOCK) disable iff (RST)
    state == ST_RUN && !START_CMD && coast_inhibit |=> state == ST_DECEL)
    else $error("coasting taken while a stop function was active");
  chk_decel_code: assert property (@(posedge CLOCK) disable iff (RST)
    state == ST_RUN && !START_CMD
      && (coast_delay_setting == COAST_DECEL_A || coast_delay_setting == COAST_DECEL_B)
      |=> state == ST_DECEL ##1 (DRIVE.decel_stop || interlock || $past(interlock)))
    else $error("decelerating stop not taken");
  chk_follow_cmd: assert property (@(posedge CLOCK) disable iff (RST)
    state == ST_COAST_WAIT && !interlock |=> DRIVE.follow_cmd && DRIVE.running)
    else $error("frequency command not followed during coast delay");
  chk_restart_base: assert property (@(posedge CLOCK) disable iff (RST)
    state == ST_COASTING && START_CMD |=> state == ST_RUN && DRIVE.from_start)
    else $error("restart from coasting not flagged");
  chk_zero_hold: assert property (@(posedge CLOCK) disable iff (RST)
    state == ST_COASTING && PREEXCITE && !interlock |=> DRIVE.zero_hold && DRIVE.output_on)
    else $error("pre-excitation did not hold the motor");
  chk_fixed_duty: assert property (@(posedge CLOCK) disable iff (RST)
    regen_function_select == REGEN_NONE && rating_class == 2'h1 |=> BRAKE_DUTY == DUTY_CLASS1)
    else $error("fixed brake duty not applied");
  chk_interlock_off: assert property (@(posedge CLOCK) disable iff (RST)
    interlock |=> !DRIVE.output_on)
    else $error("output not shut off by run-enable or output-stop");
  chk_count_clear: assert property (@(posedge CLOCK) disable iff (RST)
    state == ST_COAST_WAIT && START_CMD |=> sec_cnt == '0 && state == ST_RUN)
    else $error("coast counter not cleared on start");

endmodule
`default_nettype wire

// file: dv/conv_unit_model.sv
// behavioural model of the converter unit that drives the run-enable contact
`timescale 1ns/1ps
`default_nettype none
module conv_unit_model (
  // clock and reset
  input  wire logic CLOCK,
  input  wire logic RST,
  // commanded behaviour
  input  wire logic pos_logic,
  input  wire logic fault,
  input  wire logic slow,
  // operation-enable output
  output var  logic ready_out
);
  logic stage;
  logic late;
  // --------------------------------
  // enable level, shutoff asked on fault
  // --------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      stage <= pos_logic;
      late  <= pos_logic;
    end else begin
      stage <= pos_logic ? !fault : fault;
      late  <= stage;
    end
  end
  // prompt or one cycle late answer
  always_comb begin
    ready_out = slow ? late : stage;
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench of the stop and brake select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  import stop_brake_pkg::*;
  localparam int TICKS = 8;
  logic        CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        START_CMD, MOTOR_STOPPED, PREEXCITE, RUN_ENABLE_IN, term, comm;
  logic [3:0]  stopf;
  logic        pos, fault, slow;
  drive_s      drv;
  logic [6:0]  duty;
  int          n_mismatch, tests_run, n, i;
  logic [6:0]  cls [3] = '{7'h00, 7'h03, 7'h02};
  stop_brake_select #(.TICK_CYCLES(TICKS)) DUT (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .START_CMD(START_CMD), .MOTOR_STOPPED(MOTOR_STOPPED),
    .PREEXCITE(PREEXCITE), .POSITION_CTRL(stopf[0]), .POWER_FAIL_STOP(stopf[1]),
    .PANEL_STOP(stopf[2]), .COMM_ERROR_STOP(stopf[3]), .RUN_ENABLE_IN(RUN_ENABLE_IN),
    .OUTPUT_STOP_TERM(term), .OUTPUT_STOP_COMM(comm), .DRIVE(drv), .BRAKE_DUTY(duty));
  conv_unit_model CONV (.CLOCK(CLOCK), .RST(RST), .pos_logic(pos), .fault(fault),
    .slow(slow), .ready_out(RUN_ENABLE_IN));
  // clock
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    if (PREADY !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    `CHK("write error flag", xe, e)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("read data", x, r)
    `CHK("read error flag", xe, e)
  endtask
  // wait for one drive bit to reach a level, counting cycles
  task automatic waitb(input int b, input logic v, output int c);
    for (c = 0; c < 200 && drv[b] !== v; c++) @(negedge CLOCK);
    if (c == 200) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic set_start(input logic v);
    @(posedge CLOCK);
    START_CMD <= v;
  endtask
  // motor reports standstill, sequencer back to idle
  task automatic stop_end();
    @(posedge CLOCK);
    MOTOR_STOPPED <= 1'b1;
    repeat (3) @(posedge CLOCK);
    MOTOR_STOPPED <= 1'b0;
    @(negedge CLOCK);
    `CHK("idle drive", 6'h00, drv)
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs();
    rd(OFS_COAST, 32'h270F, 1'b0);
    rd(OFS_POL, 32'h0, 1'b0);
    rd(OFS_DUTY, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(OFS_DUTY, 32'd101, 1'b1);
    rd(OFS_DUTY, 32'h0, 1'b0);
    wr(OFS_DUTY, 32'd100, 1'b0);
    wr(OFS_REGEN, 32'd3, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_brake();
    for (i = 0; i < 3; i++) begin
      wr(OFS_RATING, i, 1'b0);
      repeat (2) @(negedge CLOCK);
      `CHK("fixed duty", cls[i], duty)
    end
    wr(OFS_REGEN, 32'd1, 1'b0);
    wr(OFS_DUTY, 32'd10, 1'b0);
    repeat (2) @(negedge CLOCK);
    `CHK("set duty", 7'd10, duty)
    wr(OFS_DUTY, 32'd6, 1'b0);
    repeat (2) @(negedge CLOCK);
    `CHK("heavy duty", 7'd6, duty)
    wr(OFS_REGEN, 32'd2, 1'b0);
    wr(OFS_DUTY, 32'd20, 1'b0);
    repeat (2) @(negedge CLOCK);
    `CHK("set duty", 7'd20, duty)
    $display("test brake done");
  endtask
  task automatic t_coast();
    wr(OFS_COAST, 32'd1002, 1'b0);
    set_start(1'b1);
    waitb(5, 1'b1, n);
    set_start(1'b0);
    repeat (12) @(negedge CLOCK);
    set_start(1'b1);
    rd(OFS_STATUS, 32'h1001, 1'b0);
    set_start(1'b0);
    repeat (8) @(negedge CLOCK);
    `CHK("output kept", 1'b1, drv.output_on)
    `CHK("follows command", 1'b1, drv.follow_cmd)
    waitb(4, 1'b0, n);
    `CHK("delay in window", 1'b1, n + 7 >= 2 * TICKS && n + 7 <= 2 * TICKS + 4)
    `CHK("running off", 1'b0, drv.running)
    `CHK("no decel", 1'b0, drv.decel_stop)
    @(posedge CLOCK);
    PREEXCITE <= 1'b1;
    waitb(1, 1'b1, n);
    `CHK("hold in time", 1'b1, n <= 3)
    @(posedge CLOCK);
    PREEXCITE <= 1'b0;
    set_start(1'b1);
    waitb(0, 1'b1, n);
    `CHK("restart in time", 1'b1, n <= 3)
    wr(OFS_COAST, 32'd0, 1'b0);
    set_start(1'b0);
    waitb(4, 1'b0, n);
    `CHK("zero delay", 1'b1, n <= 4)
    stop_end();
    $display("test coast done");
  endtask
  // decel expected for both codes and under each stop function
  task automatic t_decel();
    for (i = 0; i < 6; i++) begin
      @(posedge CLOCK);
      stopf <= (i < 2) ? 4'h0 : 4'h1 << (i - 2);
      wr(OFS_COAST, (i == 0) ? 32'd9999 : (i == 1) ? 32'd8888 : 32'd1000, 1'b0);
      set_start(1'b1);
      waitb(5, 1'b1, n);
      set_start(1'b0);
      waitb(2, 1'b1, n);
      `CHK("decel output on", 1'b1, drv.output_on)
      stop_end();
    end
    @(posedge CLOCK);
    stopf <= 4'h0;
    $display("test decel done");
  endtask
  task automatic t_interlock();
    wr(OFS_POL, 32'd1, 1'b0);
    pos <= 1'b1;
    slow <= 1'b1;
    set_start(1'b1);
    waitb(5, 1'b1, n);
    @(posedge CLOCK);
    fault <= 1'b1;
    waitb(4, 1'b0, n);
    `CHK("shutoff in time", 1'b1, n <= 5)
    fault <= 1'b0;
    waitb(4, 1'b1, n);
    wr(OFS_POL, 32'd2, 1'b0);
    pos <= 1'b0;
    waitb(4, 1'b0, n);
    `CHK("open term stops", 1'b1, n <= 4)
    rd(OFS_STATUS, 32'h4001, 1'b0);
    wr(OFS_POL, 32'd0, 1'b0);
    waitb(4, 1'b1, n);
    `CHK("normally open", 1'b1, drv.running)
    wr(OFS_POL, 32'd4, 1'b0);
    term <= 1'b1;
    waitb(4, 1'b1, n);
    `CHK("closed term runs", 1'b1, drv.running)
    comm <= 1'b1;
    waitb(4, 1'b0, n);
    `CHK("open comm stops", 1'b1, n <= 4)
    @(posedge CLOCK);
    {term, comm} <= 2'b00;
    wr(OFS_POL, 32'd0, 1'b0);
    waitb(4, 1'b1, n);
    set_start(1'b0);
    waitb(4, 1'b0, n);
    `CHK("coast after stop", 1'b0, drv.running)
    stop_end();
    $display("test interlock done");
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    {RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 43'h0};
    {START_CMD, MOTOR_STOPPED, PREEXCITE, term, comm, stopf} = 9'h0;
    {pos, fault, slow, n_mismatch, tests_run} = '0;
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    @(negedge CLOCK);
    `CHK("reset duty", 7'h00, duty)
    t_regs();
    t_brake();
    t_coast();
    t_decel();
    t_interlock();
    give_verdict();
  end
endmodule
`default_nettype wire
